// File: verilog/imc_pkg.sv
package imc_pkg;
	// ==========================================================
	// sizes
	localparam int GROUPS = 11;
	localparam int GROUP_BITS = 8;
	localparam int PINS = 8;
	localparam int SRC_BITS = GROUPS * GROUP_BITS;
	localparam int CODE_W = 16;
	localparam int LEVEL_W = 5;
	localparam int PRIO_W = 4;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_SENSE = 8'h04;
	localparam logic [7:0] OFS_PIN_REQ = 8'h08;
	localparam logic [7:0] OFS_EVENT = 8'h0C;
	localparam logic [7:0] OFS_PRIO_C = 8'h10;
	localparam logic [7:0] OFS_PRIO_D = 8'h14;
	localparam logic [7:0] OFS_PRIO_P0 = 8'h18;
	localparam logic [7:0] OFS_PRIO_P1 = 8'h1C;
	localparam logic [7:0] OFS_MASK_BASE = 8'h40;
	localparam logic [7:0] OFS_MCLR_BASE = 8'h80;
	localparam logic [7:0] OFS_GROUP_SPAN = 8'h2C;

	// ==========================================================
	// fields and reset values
	localparam int NMI_EDGE_BIT = 0;
	localparam logic [1:0] SENSE_FALL = 2'h0;
	localparam logic [1:0] SENSE_RISE = 2'h1;
	localparam logic [1:0] SENSE_LOW = 2'h2;
	localparam logic [1:0] SENSE_HIGH = 2'h3;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [15:0] PRIO_RESET = 16'h0000;
	localparam logic [31:0] PRIOP_RESET = 32'h0000_0000;

	// reserved bits per group read as zero and never request
	localparam logic [7:0] GROUP_VALID [GROUPS] = '{
		8'hFF, 8'hFF, 8'h1F, 8'h00, 8'h08, 8'hFF,
		8'hFF, 8'h1F, 8'h1F, 8'h1F, 8'h39
	};

	// ==========================================================
	// levels and event codes
	localparam logic [LEVEL_W-1:0] LEVEL_NMI = 5'h10;
	localparam logic [LEVEL_W-1:0] LEVEL_DEBUG = 5'h0F;
	localparam logic [CODE_W-1:0] CODE_NMI = 16'h01C0;
	localparam logic [CODE_W-1:0] CODE_DEBUG = 16'h05E0;
	localparam logic [CODE_W-1:0] CODE_PIN_BASE = 16'h0600;
	localparam logic [CODE_W-1:0] CODE_PERIPH_BASE = 16'h0800;
	localparam logic [CODE_W-1:0] CODE_STEP = 16'h0020;
	localparam logic [31:0] DEBUG_VECTOR_OFS = 32'h0000_0600;

	// ==========================================================
	// bus answer sequence, one bit flips per step except DONE back to IDLE
	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_WAIT = 2'b01,
		APB_DONE = 2'b11
	} imc_apb_t;
endpackage

// File: verilog/imc_pin_detect.sv
`timescale 1ns/1ps
module imc_pin_detect
	import imc_pkg::*;
#(
	parameter int NPINS = 8
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [NPINS-1:0] pinsN,
	input wire logic [2*NPINS-1:0] senseCtrl,
	input wire logic reqRead,
	input wire logic reqWrite,
	input wire logic [NPINS-1:0] reqWriteData,
	output logic [NPINS-1:0] request
);
	logic [NPINS-1:0] prev_reg;
	logic [NPINS-1:0] prev_next;
	logic [NPINS-1:0] armed_reg;
	logic [NPINS-1:0] armed_next;
	logic [NPINS-1:0] req_reg;
	logic [NPINS-1:0] req_next;

	initial begin
		if (NPINS < 1 || NPINS > 8) $error("imc_pin_detect: NPINS out of range");
	end

	// ==========================================================
	// sense and request bits
	always_comb begin
		logic [1:0] mode;
		logic hit;
		logic clr;
		mode = SENSE_FALL;
		hit = 1'b0;
		clr = 1'b0;
		prev_next = pinsN;
		armed_next = armed_reg;
		req_next = req_reg;
		for (int i = 0; i < NPINS; i++) begin
			mode = senseCtrl[2*i +: 2];
			if (mode == SENSE_LOW || mode == SENSE_HIGH) begin
				// level mode follows the pin only, writes have no effect
				req_next[i] = (mode == SENSE_LOW) ? ~pinsN[i] : pinsN[i];
				armed_next[i] = 1'b0;
			end else begin
				hit = (mode == SENSE_FALL) ? (prev_reg[i] & ~pinsN[i])
					: (~prev_reg[i] & pinsN[i]);
				// clear only after a read saw 1; a new edge beats the clear
				clr = reqWrite & ~reqWriteData[i] & armed_reg[i];
				req_next[i] = hit | (req_reg[i] & ~clr);
				if (reqRead && req_reg[i]) begin
					armed_next[i] = 1'b1;
				end else if (reqWrite) begin
					armed_next[i] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prev_reg <= '1;
			armed_reg <= '0;
			req_reg <= '0;
		end else begin
			prev_reg <= prev_next;
			armed_reg <= armed_next;
			req_reg <= req_next;
		end
	end

	assign request = req_reg;
endmodule

// File: verilog/imc_top.sv
`timescale 1ns/1ps
// Contract
// - each mask-clear register is eight bits, write only, one per source group
// - writing 1 clears the matching mask bit; writing 0 leaves it
// - mask-clear bits map to sources exactly as mask bits do
// - reserved mask-clear bits read 0; software writes 0 there
// - levels 0 to 16, 16 highest; level 0 means ignored
// - nmi is level 16, taken when exception block bit is 0
// - in sleep or standby nmi is taken regardless and wakes the chip
// - nmi is edge detected, edge chosen by control register 0 bit
// - taking nmi, pin or peripheral interrupts leaves core mask level alone
// - debug interrupt taken between instructions, mask below 15, block bit 0
// - debug take saves pc and status, code 5E0, jumps base plus 600
// - eight active-low pins, level or edge, priority 0..15 from regs C, D
// - peripherals share one entry; each loads its own event code
// - each peripheral module has priority 0..15 from its registers
// - debug interrupt priority fixed at 15
// - writing 1 to a mask bit masks; 0 does nothing; read 0 is unmasked
// - level pin request follows the pin only; writes do not touch it
module imc_top
	import imc_pkg::*;
#(
	parameter int NGROUPS = imc_pkg::GROUPS
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [imc_pkg::PINS-1:0] extIntPinsN,
	input wire logic nmiPin,
	input wire logic [imc_pkg::SRC_BITS-1:0] periphReq,
	input wire logic debugIntCmd,
	input wire logic coreExceptionBlock,
	input wire logic [3:0] coreIntMaskLevel,
	input wire logic coreLowPower,
	input wire logic coreBetweenInstr,
	input wire logic [31:0] corePc,
	input wire logic [31:0] coreStatus,
	input wire logic [31:0] vectorBase,
	input wire logic intAck,
	output logic intReq,
	output logic [imc_pkg::LEVEL_W-1:0] intLevel,
	output logic [imc_pkg::CODE_W-1:0] intCode,
	output logic nmiWake,
	output logic debugTaken,
	output logic [31:0] savedPc,
	output logic [31:0] savedStatus,
	output logic [31:0] branchTarget
);
	initial begin
		if (NGROUPS != GROUPS) $error("imc_top: group count is fixed by the source map");
	end

	// ==========================================================
	// helpers
	function automatic logic [PRIO_W-1:0] nib(input logic [31:0] word, input int idx);
		nib = word[PRIO_W*idx +: PRIO_W];
	endfunction

	function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] base,
		output int grp);
		logic [7:0] rel;
		rel = addr - base;
		grp = int'(rel[7:2]);
		hitAddr = (addr >= base) && (rel < OFS_GROUP_SPAN) && (rel[1:0] == 2'b00);
	endfunction

	// ==========================================================
	// register state
	logic [7:0] mask_reg [GROUPS];
	logic [7:0] mask_next [GROUPS];
	logic [0:0] ctrl0_reg;
	logic [0:0] ctrl0_next;
	logic [15:0] sense_reg;
	logic [15:0] sense_next;
	logic [15:0] prioC_reg;
	logic [15:0] prioC_next;
	logic [15:0] prioD_reg;
	logic [15:0] prioD_next;
	logic [31:0] prioP0_reg;
	logic [31:0] prioP0_next;
	logic [31:0] prioP1_reg;
	logic [31:0] prioP1_next;
	logic [CODE_W-1:0] event_reg;
	logic [CODE_W-1:0] event_next;

	imc_apb_t apbState_reg;
	imc_apb_t apbState_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;

	logic [PINS-1:0] pinReq;
	logic busDone;
	logic pinReqRead;
	logic pinReqWrite;
	logic debugAccept;
	logic nmiAccept;

	// a transfer completes at the edge where the master sees pready
	assign busDone = psel & penable & pready_reg;
	assign pinReqRead = busDone & ~pwrite & (paddr == OFS_PIN_REQ);
	assign pinReqWrite = busDone & pwrite & (paddr == OFS_PIN_REQ);

	imc_pin_detect #(
		.NPINS(PINS)
	) pinDetect (
		.sys_clk(sys_clk),
		.srst(srst),
		.pinsN(extIntPinsN),
		.senseCtrl(sense_reg),
		.reqRead(pinReqRead),
		.reqWrite(pinReqWrite),
		.reqWriteData(pwdata[PINS-1:0]),
		.request(pinReq)
	);

	// ==========================================================
	// apb slave: one wait state, answer registered
	always_comb begin
		logic [31:0] rd;
		logic err;
		int g;
		rd = '0;
		err = 1'b0;
		g = 0;
		apbState_next = apbState_reg;
		pready_next = 1'b0;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		if (hitAddr(paddr, OFS_MASK_BASE, g)) begin
			rd = {24'h0, mask_reg[g] & GROUP_VALID[g]};
		end else if (hitAddr(paddr, OFS_MCLR_BASE, g)) begin
			rd = '0;
		end else begin
			unique case (paddr)
				OFS_CTRL0: rd = {31'h0, ctrl0_reg};
				OFS_SENSE: rd = {16'h0, sense_reg};
				OFS_PIN_REQ: rd = {24'h0, pinReq};
				OFS_EVENT: rd = {16'h0, event_reg};
				OFS_PRIO_C: rd = {16'h0, prioC_reg};
				OFS_PRIO_D: rd = {16'h0, prioD_reg};
				OFS_PRIO_P0: rd = prioP0_reg;
				OFS_PRIO_P1: rd = prioP1_reg;
				default: err = 1'b1;
			endcase
		end
		unique case (apbState_reg)
			APB_IDLE: begin
				if (psel && !penable) begin
					apbState_next = APB_WAIT;
				end
			end
			APB_WAIT: begin
				if (psel && penable) begin
					apbState_next = APB_DONE;
					pready_next = 1'b1;
					prdata_next = (pwrite || err) ? 32'h0 : rd;
					pslverr_next = err;
				end else if (!psel) begin
					apbState_next = APB_IDLE;
				end
			end
			APB_DONE: begin
				apbState_next = (psel && !penable) ? APB_WAIT : APB_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			apbState_reg <= APB_IDLE;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			apbState_reg <= apbState_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// ==========================================================
	// configuration registers and masks
	always_comb begin
		int g;
		g = 0;
		ctrl0_next = ctrl0_reg;
		sense_next = sense_reg;
		prioC_next = prioC_reg;
		prioD_next = prioD_reg;
		prioP0_next = prioP0_reg;
		prioP1_next = prioP1_reg;
		mask_next = mask_reg;
		if (busDone && pwrite) begin
			if (hitAddr(paddr, OFS_MASK_BASE, g)) begin
				mask_next[g] = mask_reg[g] | (pwdata[7:0] & GROUP_VALID[g]);
			end else if (hitAddr(paddr, OFS_MCLR_BASE, g)) begin
				// same bit layout as the mask registers
				mask_next[g] = mask_reg[g] & ~pwdata[7:0];
			end else begin
				unique case (paddr)
					OFS_CTRL0: ctrl0_next = pwdata[NMI_EDGE_BIT +: 1];
					OFS_SENSE: sense_next = pwdata[15:0];
					OFS_PRIO_C: prioC_next = pwdata[15:0];
					OFS_PRIO_D: prioD_next = pwdata[15:0];
					OFS_PRIO_P0: prioP0_next = pwdata;
					OFS_PRIO_P1: prioP1_next = pwdata;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl0_reg <= '0;
			sense_reg <= PRIO_RESET;
			prioC_reg <= PRIO_RESET;
			prioD_reg <= PRIO_RESET;
			prioP0_reg <= PRIOP_RESET;
			prioP1_reg <= PRIOP_RESET;
			for (int i = 0; i < GROUPS; i++) begin
				mask_reg[i] <= MASK_RESET;
			end
		end else begin
			ctrl0_reg <= ctrl0_next;
			sense_reg <= sense_next;
			prioC_reg <= prioC_next;
			prioD_reg <= prioD_next;
			prioP0_reg <= prioP0_next;
			prioP1_reg <= prioP1_next;
			mask_reg <= mask_next;
		end
	end

	// ==========================================================
	// nmi edge and debug command capture
	logic nmiPrev_reg;
	logic nmiPrev_next;
	logic nmiPend_reg;
	logic nmiPend_next;
	logic dbgPend_reg;
	logic dbgPend_next;
	logic nmiEdge;

	// pin taken as synchronous; a one-cycle pulse gives a clean edge
	assign nmiEdge = ctrl0_reg[0] ? (~nmiPrev_reg & nmiPin)
		: (nmiPrev_reg & ~nmiPin);

	always_comb begin
		nmiPrev_next = nmiPin;
		// a new edge wins over the acceptance that clears it
		nmiPend_next = nmiEdge | (nmiPend_reg & ~nmiAccept);
		dbgPend_next = debugIntCmd | (dbgPend_reg & ~debugAccept);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			nmiPrev_reg <= 1'b0;
			nmiPend_reg <= 1'b0;
			dbgPend_reg <= 1'b0;
		end else begin
			nmiPrev_reg <= nmiPrev_next;
			nmiPend_reg <= nmiPend_next;
			dbgPend_reg <= dbgPend_next;
		end
	end

	// ==========================================================
	// arbitration: ties go to the lowest source index
	logic [LEVEL_W-1:0] bestLevel;
	logic [CODE_W-1:0] bestCode;
	logic nmiEligible;

	assign nmiEligible = nmiPend_reg & (~coreExceptionBlock | coreLowPower);

	always_comb begin
		logic [LEVEL_W-1:0] lvl;
		logic [PRIO_W-1:0] p;
		lvl = '0;
		p = '0;
		bestLevel = '0;
		bestCode = '0;
		for (int i = 0; i < PINS; i++) begin
			p = (i < 4) ? nib({16'h0, prioC_reg}, i) : nib({16'h0, prioD_reg}, i - 4);
			lvl = {1'b0, p};
			if (pinReq[i] && !mask_reg[0][i] && lvl > bestLevel) begin
				bestLevel = lvl;
				bestCode = CODE_PIN_BASE + CODE_STEP * CODE_W'(i);
			end
		end
		for (int g = 1; g < GROUPS; g++) begin
			p = (g < 9) ? nib(prioP0_reg, g - 1) : nib(prioP1_reg, g - 9);
			lvl = {1'b0, p};
			for (int b = 0; b < GROUP_BITS; b++) begin
				if (periphReq[g*GROUP_BITS + b] && GROUP_VALID[g][b] && !mask_reg[g][b]
					&& lvl > bestLevel) begin
					bestLevel = lvl;
					// each source carries its own code into one shared entry
					bestCode = CODE_PERIPH_BASE
						+ CODE_STEP * CODE_W'((g - 1) * GROUP_BITS + b);
				end
			end
		end
		if (nmiEligible) begin
			bestLevel = LEVEL_NMI;
			bestCode = CODE_NMI;
		end
	end

	// ==========================================================
	// core side: request, acceptance, debug entry
	logic intReq_reg;
	logic intReq_next;
	logic [LEVEL_W-1:0] intLevel_reg;
	logic [LEVEL_W-1:0] intLevel_next;
	logic [CODE_W-1:0] intCode_reg;
	logic [CODE_W-1:0] intCode_next;
	logic nmiWake_reg;
	logic nmiWake_next;
	logic debugTaken_reg;
	logic debugTaken_next;
	logic [31:0] savedPc_reg;
	logic [31:0] savedPc_next;
	logic [31:0] savedStatus_reg;
	logic [31:0] savedStatus_next;
	logic [31:0] branch_reg;
	logic [31:0] branch_next;

	// level 0 never wins since only higher levels than the mask are offered
	assign nmiAccept = intAck & intReq_reg & (intCode_reg == CODE_NMI);
	assign debugAccept = dbgPend_reg & coreBetweenInstr & ~coreExceptionBlock
		& ({1'b0, coreIntMaskLevel} < LEVEL_DEBUG) & ~nmiEligible;

	always_comb begin
		intReq_next = 1'b0;
		intLevel_next = '0;
		intCode_next = '0;
		// the core mask level is only read here, never driven
		if (bestLevel == LEVEL_NMI
			|| (!coreExceptionBlock && bestLevel > {1'b0, coreIntMaskLevel})) begin
			intReq_next = ~(intAck & intReq_reg);
			intLevel_next = bestLevel;
			intCode_next = bestCode;
		end
		event_next = event_reg;
		if (intAck && intReq_reg) begin
			event_next = intCode_reg;
		end
		nmiWake_next = nmiEdge & coreLowPower;
		debugTaken_next = debugAccept;
		savedPc_next = savedPc_reg;
		savedStatus_next = savedStatus_reg;
		branch_next = branch_reg;
		if (debugAccept) begin
			savedPc_next = corePc;
			savedStatus_next = coreStatus;
			event_next = CODE_DEBUG;
			branch_next = vectorBase + DEBUG_VECTOR_OFS;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			intReq_reg <= 1'b0;
			intLevel_reg <= '0;
			intCode_reg <= '0;
			event_reg <= '0;
			nmiWake_reg <= 1'b0;
			debugTaken_reg <= 1'b0;
			savedPc_reg <= '0;
			savedStatus_reg <= '0;
			branch_reg <= '0;
		end else begin
			intReq_reg <= intReq_next;
			intLevel_reg <= intLevel_next;
			intCode_reg <= intCode_next;
			event_reg <= event_next;
			nmiWake_reg <= nmiWake_next;
			debugTaken_reg <= debugTaken_next;
			savedPc_reg <= savedPc_next;
			savedStatus_reg <= savedStatus_next;
			branch_reg <= branch_next;
		end
	end

	assign intReq = intReq_reg;
	assign intLevel = intLevel_reg;
	assign intCode = intCode_reg;
	assign nmiWake = nmiWake_reg;
	assign debugTaken = debugTaken_reg;
	assign savedPc = savedPc_reg;
	assign savedStatus = savedStatus_reg;
	assign branchTarget = branch_reg;
endmodule

// File: verification/imc_top_monitor.sv
`timescale 1ns/1ps
module imc_top_monitor
	import imc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic coreExceptionBlock,
	input wire logic [3:0] coreIntMaskLevel,
	input wire logic coreLowPower,
	input wire logic coreBetweenInstr,
	input wire logic [31:0] corePc,
	input wire logic [31:0] coreStatus,
	input wire logic [31:0] vectorBase,
	input wire logic intAck,
	input wire logic intReq,
	input wire logic [imc_pkg::LEVEL_W-1:0] intLevel,
	input wire logic [imc_pkg::CODE_W-1:0] intCode,
	input wire logic nmiWake,
	input wire logic debugTaken,
	input wire logic [31:0] savedPc,
	input wire logic [31:0] savedStatus,
	input wire logic [31:0] branchTarget
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	// ==========================================================
	// bus
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	property p_apb_answer;
		s_setup ##1 (psel && penable) |=> s_answer;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("late or long bus answer");
	property p_mclr_zero;
		psel && penable && pready && !pwrite && paddr >= OFS_MCLR_BASE
			&& paddr <= OFS_MCLR_BASE + 8'h28 |-> prdata == 32'h0;
	endproperty
	a_mclr_zero: assert property (p_mclr_zero) else $error("mask clear read not zero");
	// ==========================================================
	// requests to the core
	property p_level_range;
		intReq |-> intLevel != '0 && intLevel <= LEVEL_NMI;
	endproperty
	a_level_range: assert property (p_level_range) else $error("level out of range");
	property p_nmi_code;
		intReq && intLevel == LEVEL_NMI |-> intCode == CODE_NMI;
	endproperty
	a_nmi_code: assert property (p_nmi_code) else $error("top level without nmi code");
	property p_gate;
		intReq && intLevel != LEVEL_NMI |-> !$past(coreExceptionBlock)
			&& intLevel > {1'b0, $past(coreIntMaskLevel)};
	endproperty
	a_gate: assert property (p_gate) else $error("request not above core mask");
	property p_ack_drop;
		intAck && intReq |=> !intReq;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");
	property p_wake;
		nmiWake |-> $past(coreLowPower) ##1 !nmiWake;
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake pulse");
	// ==========================================================
	// debug port
	property p_dbg_gate;
		debugTaken |-> $past(coreBetweenInstr) && !$past(coreExceptionBlock)
			&& $past(coreIntMaskLevel) < 4'hF;
	endproperty
	a_dbg_gate: assert property (p_dbg_gate) else $error("debug taken while barred");
	property p_dbg_save;
		debugTaken |-> savedPc == $past(corePc) && savedStatus == $past(coreStatus)
			&& branchTarget == $past(vectorBase) + DEBUG_VECTOR_OFS;
	endproperty
	a_dbg_save: assert property (p_dbg_save) else $error("debug save wrong");
endmodule

bind imc_top imc_top_monitor u_mon(.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.coreExceptionBlock(coreExceptionBlock), .coreIntMaskLevel(coreIntMaskLevel),
	.coreLowPower(coreLowPower), .coreBetweenInstr(coreBetweenInstr), .corePc(corePc),
	.coreStatus(coreStatus), .vectorBase(vectorBase), .intAck(intAck), .intReq(intReq),
	.intLevel(intLevel), .intCode(intCode), .nmiWake(nmiWake), .debugTaken(debugTaken),
	.savedPc(savedPc), .savedStatus(savedStatus), .branchTarget(branchTarget));

// File: verification/imc_core_model.sv
`timescale 1ns/1ps
module imc_core_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic intReq,
	input wire logic [1:0] ackDelay,
	output logic intAck
);
	logic [1:0] waitCnt;
	// ==========================================================
	// takes a request after ackDelay cycles; a slow core leaves it standing
	always_ff @(posedge sys_clk) begin
		intAck <= 1'b0;
		waitCnt <= 2'h0;
		if (!srst && intReq && !intAck) begin
			if (waitCnt == ackDelay) begin
				intAck <= 1'b1;
			end else begin
				waitCnt <= waitCnt + 2'h1;
			end
		end
	end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
	import imc_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, savedPc, savedStatus, branchTarget, r;
	logic [31:0] corePc = 32'h0;
	logic [31:0] coreStatus = 32'h0;
	logic [31:0] vectorBase = 32'h0;
	logic pready, pslverr, intReq, intAck, nmiWake, debugTaken;
	logic [PINS-1:0] extIntPinsN = 8'hFF;
	logic nmiPin = 1'b0;
	logic debugIntCmd = 1'b0;
	logic coreExceptionBlock = 1'b0;
	logic coreLowPower = 1'b0;
	logic coreBetweenInstr = 1'b1;
	logic [SRC_BITS-1:0] periphReq = '0;
	logic [3:0] coreIntMaskLevel = 4'h0;
	logic [LEVEL_W-1:0] intLevel;
	logic [CODE_W-1:0] intCode;
	logic [1:0] ackDelay = 2'h0;
	logic [32:0] expQ[$];
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	always #2 sys_clk = ~sys_clk;
	imc_top dut(.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extIntPinsN(extIntPinsN), .nmiPin(nmiPin), .periphReq(periphReq),
		.debugIntCmd(debugIntCmd), .coreExceptionBlock(coreExceptionBlock),
		.coreIntMaskLevel(coreIntMaskLevel), .coreLowPower(coreLowPower),
		.coreBetweenInstr(coreBetweenInstr), .corePc(corePc), .coreStatus(coreStatus),
		.vectorBase(vectorBase), .intAck(intAck), .intReq(intReq), .intLevel(intLevel),
		.intCode(intCode), .nmiWake(nmiWake), .debugTaken(debugTaken), .savedPc(savedPc),
		.savedStatus(savedStatus), .branchTarget(branchTarget));
	imc_core_model core(.sys_clk(sys_clk), .srst(srst), .intReq(intReq), .ackDelay(ackDelay),
		.intAck(intAck));
	// ==========================================================
	// checking
	task results;
		$display("mismatches %0d comparisons %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// read results are paired with the oldest note in issue order
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			results();
		end
		if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, expQ.pop_front());
	end
	// ==========================================================
	// bus and wait tasks
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		if (!w) expQ.push_back(e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk iff pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask
	task ackCode(input logic [15:0] c, input logic [LEVEL_W-1:0] lvl);
		@(posedge sys_clk iff intAck);
		chk(intLevel, lvl);
		chk(intCode, c);
		periphReq <= '0;
		rd(OFS_EVENT, {16'h0, c});
	endtask
	// ==========================================================
	// scenarios
	initial begin
		void'($urandom(19));
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		apb(1'b0, 8'hF0, 32'h0, {1'b1, 32'h0});
		for (int g = 0; g < GROUPS; g++) begin
			rd(OFS_MASK_BASE + 8'(4 * g), 32'h0);
			wr(OFS_MASK_BASE + 8'(4 * g), 32'hFF);
			wr(OFS_MASK_BASE + 8'(4 * g), 32'h00);
			rd(OFS_MASK_BASE + 8'(4 * g), {24'h0, GROUP_VALID[g]});
			r = $urandom;
			wr(OFS_MCLR_BASE + 8'(4 * g), {24'h0, r[7:0] & GROUP_VALID[g]});
			rd(OFS_MASK_BASE + 8'(4 * g), {24'h0, GROUP_VALID[g] & ~r[7:0]});
			rd(OFS_MCLR_BASE + 8'(4 * g), 32'h0);
			wr(OFS_MCLR_BASE + 8'(4 * g), {24'h0, GROUP_VALID[g]});
		end
		// masked peripheral source, slow core
		ackDelay <= 2'h3;
		coreIntMaskLevel <= 4'h4;
		wr(OFS_PRIO_P0, 32'h5);
		wr(OFS_MASK_BASE + 8'h04, 32'h08);
		periphReq[11] <= 1'b1;
		repeat (4) begin
			@(posedge sys_clk);
			chk(intReq, 1'b0);
		end
		wr(OFS_MCLR_BASE + 8'h04, 32'h08);
		ackCode(16'h0860, 5'h05);
		// edge-sensed pin, prompt core
		ackDelay <= 2'h0;
		coreIntMaskLevel <= 4'h0;
		wr(OFS_PRIO_C, 32'h300);
		extIntPinsN[2] <= 1'b0;
		repeat (4) @(posedge sys_clk);
		extIntPinsN[2] <= 1'b1;
		ackCode(16'h0640, 5'h03);
		rd(OFS_PIN_REQ, 32'h04);
		wr(OFS_PIN_REQ, 32'h0);
		rd(OFS_PIN_REQ, 32'h0);
		// level-sensed pin ignores writes
		wr(OFS_MASK_BASE, 32'h04);
		wr(OFS_SENSE, 32'h20);
		wr(OFS_PIN_REQ, 32'h0);
		wr(OFS_MCLR_BASE, 32'h04);
		extIntPinsN[2] <= 1'b0;
		wr(OFS_PIN_REQ, 32'h0);
		rd(OFS_PIN_REQ, 32'h04);
		extIntPinsN[2] <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(OFS_PIN_REQ, 32'h0);
		// rising-sensed pin 4 ignores the falling edge
		wr(OFS_PRIO_D, 32'h6);
		wr(OFS_MASK_BASE, 32'h10);
		wr(OFS_SENSE, 32'h120);
		wr(OFS_PIN_REQ, 32'h0);
		wr(OFS_MCLR_BASE, 32'h10);
		extIntPinsN[4] <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd(OFS_PIN_REQ, 32'h0);
		extIntPinsN[4] <= 1'b1;
		ackCode(16'h0680, 5'h06);
		rd(OFS_PIN_REQ, 32'h10);
		wr(OFS_PIN_REQ, 32'h0);
		// rising nmi in low power with the block bit set
		ackDelay <= 2'h3;
		wr(OFS_CTRL0, 32'h1);
		coreLowPower <= 1'b1;
		coreExceptionBlock <= 1'b1;
		nmiPin <= 1'b1;
		@(posedge sys_clk iff nmiWake);
		nmiPin <= 1'b0;
		ackCode(16'h01C0, 5'h10);
		coreLowPower <= 1'b0;
		coreExceptionBlock <= 1'b0;
		// debug command held off by mask level 15
		coreIntMaskLevel <= 4'hF;
		corePc <= $urandom;
		coreStatus <= $urandom;
		vectorBase <= $urandom;
		debugIntCmd <= 1'b1;
		@(posedge sys_clk);
		debugIntCmd <= 1'b0;
		repeat (5) begin
			@(posedge sys_clk);
			chk(debugTaken, 1'b0);
		end
		coreIntMaskLevel <= 4'hE;
		coreBetweenInstr <= 1'b0;
		repeat (3) begin
			@(posedge sys_clk);
			chk(debugTaken, 1'b0);
		end
		coreBetweenInstr <= 1'b1;
		@(posedge sys_clk iff debugTaken);
		chk(savedPc, corePc);
		chk(savedStatus, coreStatus);
		chk(branchTarget, vectorBase + 32'h600);
		rd(OFS_EVENT, 32'h5E0);
		results();
	end
endmodule
